// ===== sspis_master_model.sv
/* Far-side master: one byte per go pulse, clock rests between frames at the
   level its polarity sets. Assumes clk_i is the system clock of the slave. */
`timescale 1ns/1ns
`default_nettype none
module sspis_master_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] tx_i,
  input  wire logic       pha_i,
  input  wire logic       pol_i,
  input  wire logic       msb_i,
  input  wire logic       sdo_i,
  input  wire logic       sdo_oe_i,
  output logic            sck_o,
  output logic            sel_n_o,
  output logic            sdi_o,
  output logic [7:0]      got_o,
  output logic            done_o
);
  // Six clocks a half period keeps well under the one-sixth limit.
  int   half = 6;
  int   j;
  logic ck;
  logic line;
  // The clock stands still outside frames; polarity only inverts the pin.
  assign sck_o = ck ^ pol_i;
  // A released data line floats to its pull-up level.
  assign line = sdo_oe_i ? sdo_i : 1'b1;
  initial begin
    ck = 1'b1;
    sel_n_o = 1'b1;
    sdi_o = 1'b0;
    got_o = 8'h00;
    done_o = 1'b1;
  end
  // Phase 1 samples on the leading edge and drives on the trailing one.
  always @(posedge go_i) begin
    done_o = 1'b0;
    sel_n_o = 1'b0;
    j = msb_i ? 7 : 0;
    if (pha_i) sdi_o = tx_i[j];
    repeat (half) @(negedge clk_i);
    for (int i = 0; i < 8; i++) begin
      j = msb_i ? 7 - i : i;
      ck = 1'b0;
      if (pha_i) got_o[j] = line;
      else sdi_o = tx_i[j];
      repeat (half) @(negedge clk_i);
      ck = 1'b1;
      if (!pha_i) got_o[j] = line;
      else if (i < 7) sdi_o = tx_i[msb_i ? 6 - i : i + 1];
      repeat (half) @(negedge clk_i);
    end
    sel_n_o = 1'b1;
    // Released data shows a changed level so a stale bit is never read as valid.
    sdi_o = ~sdi_o;
    done_o = 1'b1;
  end
endmodule
`default_nettype wire

// ===== sspis_monitor.sv
/* Port checker for the serial slave channel.
   Assumes one clock domain; bound onto sspis_slave below. */
`timescale 1ns/1ns
`default_nettype none
module sspis_monitor (
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire logic                      enable_i,
  input wire logic                      wr_valid_i,
  input wire sspis_pkg::sspis_word_type wr_data_i,
  input wire logic                      rd_strobe_i,
  input wire logic [7:0]                rd_data_o,
  input wire logic                      wr_ready_o,
  input wire logic                      buffer_full_flag_o,
  input wire logic                      busy_o,
  input wire logic                      overrun_o,
  input wire logic                      intr_o,
  input wire logic                      interrupt_source_select_i
);
  import sspis_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_wr; enable_i && wr_valid_i; endsequence
  sequence s_end; $rose(buffer_full_flag_o) && !interrupt_source_select_i; endsequence
  property p_wr; s_wr |=> rd_data_o == 8'($past(wr_data_i)); endproperty
  property p_rdy; wr_ready_o; endproperty
  property p_keep; rd_strobe_i && !wr_valid_i |=> $stable(rd_data_o) || !enable_i; endproperty
  property p_clr; rd_strobe_i && !busy_o |=> !buffer_full_flag_o; endproperty
  property p_pulse; intr_o |=> !intr_o; endproperty
  property p_end; s_end |-> ##[0:2] intr_o or $past(intr_o); endproperty
  property p_ovr; overrun_o && enable_i |=> overrun_o; endproperty
  property p_stop; !enable_i |=> !busy_o; endproperty
  a_wr: assert property (p_wr) else $error("tx byte not taken");
  a_rdy: assert property (p_rdy) else $error("write refused");
  a_keep: assert property (p_keep) else $error("read moved tx byte");
  a_clr: assert property (p_clr) else $error("full flag kept");
  a_pulse: assert property (p_pulse) else $error("intr too long");
  a_end: assert property (p_end) else $error("no end intr");
  a_ovr: assert property (p_ovr) else $error("overrun lost");
  a_stop: assert property (p_stop) else $error("busy after disable");
endmodule
bind sspis_slave sspis_monitor sspis_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
  .enable_i(enable_i), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i),
  .rd_strobe_i(rd_strobe_i), .rd_data_o(rd_data_o), .wr_ready_o(wr_ready_o),
  .buffer_full_flag_o(buffer_full_flag_o), .busy_o(busy_o), .overrun_o(overrun_o),
  .intr_o(intr_o), .interrupt_source_select_i(interrupt_source_select_i));
`default_nettype wire

// ===== sspis_params.svh
/*
 * Constants for the clocked serial slave channel: field positions, reset values and
 * counts. Assumes it is included by its bare name from the package and the module.
 */
`ifndef SSPIS_PARAMS_SVH
`define SSPIS_PARAMS_SVH

`define SSPIS_DATA_W        16
`define SSPIS_DIV_MSB       15
`define SSPIS_DIV_LSB       9
`define SSPIS_PRS_W         4
`define SSPIS_PRS_SEL_BIT   15
`define SSPIS_BITS_PER_XFER 4'h8
`define SSPIS_SCLK_RATIO    6
`define SSPIS_DATA_RST      16'h0000
`define SSPIS_PRE_RST       16'h0000

`endif

// ===== sspis_pkg.sv
/*
 * Types shared by the clocked serial slave channel.
 * Assumes the parameter header is on the include path.
 */
`include "sspis_params.svh"

package sspis_pkg;

  typedef enum logic [2:0] {
    SSPIS_IDLE  = 3'b001,
    SSPIS_SHIFT = 3'b010,
    SSPIS_DONE  = 3'b100
  } sspis_state_type;

  typedef logic [`SSPIS_DATA_W-1:0] sspis_word_type;

endpackage

// ===== sspis_slave.sv
/*
 * Slave transmit/receive channel of a simple clocked serial link, with the operation
 * clock enable derived from a prescaled system clock, and the master baud figure counted on that enable.
 * Assumes an external master drives the serial clock and select, and that software
 * reaches data and status through the plain ports below.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sspis_params.svh"

module sspis_slave (
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              enable_i,
  input  wire logic                              prescaler_select_bit_i,
  input  wire logic [`SSPIS_PRS_W-1:0]           prescale_field_low_i,
  input  wire logic [`SSPIS_PRS_W-1:0]           prescale_field_high_i,
  input  wire logic                              interrupt_source_select_i,
  input  wire logic                              data_phase_bit_i,
  input  wire logic                              clock_polarity_bit_i,
  input  wire logic                              msb_first_i,
  input  wire logic                              wr_valid_i,
  output logic                                   wr_ready_o,
  input  wire sspis_pkg::sspis_word_type         wr_data_i,
  input  wire logic                              rd_strobe_i,
  output logic [7:0]                             rd_data_o,
  output logic [7:0]                             rx_data_o,
  output logic                                   rx_valid_o,
  input  wire logic                              rx_ready_i,
  output logic                                   buffer_full_flag_o,
  output logic                                   busy_o,
  output logic                                   overrun_o,
  output logic                                   intr_o,
  output logic                                   master_sck_toggle_o,
  input  wire logic                              sck_i,
  input  wire logic                              sel_n_i,
  input  wire logic                              sdi_i,
  output logic                                   sdo_o,
  output logic                                   sdo_oe_o
);
  import sspis_pkg::*;

  function automatic logic [15:0] sspis_mask(input logic [3:0] k);
    sspis_mask = 16'(({1'b0, 16'hFFFF} >> (5'd16 - {1'b0, k})));
  endfunction

  // ************************************************************
  // Operation clock enable
  // ************************************************************
  logic [15:0] pre_cnt_q;
  logic [3:0]  pre_k;
  logic        mck_en;

  assign pre_k  = prescaler_select_bit_i ? prescale_field_high_i : prescale_field_low_i;
  assign mck_en = ((pre_cnt_q & sspis_mask(pre_k)) == 16'h0000);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt_q <= `SSPIS_PRE_RST;
    end else begin
      pre_cnt_q <= pre_cnt_q + 16'h0001;
    end
  end

  // ************************************************************
  // Transmit holding register and master baud counter
  // ************************************************************
  sspis_word_type data_q;
  logic           bff_q;
  logic [6:0]     baud_q;
  logic           load;
  logic           rx_push;
  logic           bfree_pulse;

  assign wr_ready_o = 1'b1;
  assign rd_data_o  = data_q[7:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_q <= `SSPIS_DATA_RST;
    end else if (wr_valid_i) begin
      data_q <= wr_data_i;
    end
  end

  // Master baud counter: divider plus one operation clocks per half period.
  // A count already past a newly lowered divider wraps at once, not after 127.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      baud_q              <= 7'h00;
      master_sck_toggle_o <= 1'b0;
    end else if (mck_en) begin
      if (baud_q >= data_q[`SSPIS_DIV_MSB:`SSPIS_DIV_LSB]) begin
        baud_q              <= 7'h00;
        master_sck_toggle_o <= ~master_sck_toggle_o;
      end else begin
        baud_q <= baud_q + 7'h01;
      end
    end
  end

  // ************************************************************
  // Pin synchronisers and edge detection
  // ************************************************************
  logic [1:0] sck_sync_q;
  logic [1:0] sel_sync_q;
  logic [1:0] sdi_sync_q;
  logic       sck_last_q;
  logic       sck_lvl;
  logic       lead_edge;
  logic       trail_edge;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_sync_q <= 2'h3;
      sel_sync_q <= 2'h3;
      sdi_sync_q <= 2'h0;
    end else begin
      sck_sync_q <= {sck_sync_q[0], sck_i};
      sel_sync_q <= {sel_sync_q[0], sel_n_i};
      sdi_sync_q <= {sdi_sync_q[0], sdi_i};
    end
  end

  // Edges are taken only on operation clock enables, so a master faster than
  // one sixth of that clock loses edges; that limit is the master's to keep.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Rest level of a non-reversed clock, so reset shows no false edge.
      sck_last_q <= 1'b1;
    end else if (mck_en) begin
      sck_last_q <= sck_sync_q[1];
    end
  end

  assign sck_lvl    = sck_sync_q[1] ^ clock_polarity_bit_i;
  assign lead_edge  = mck_en && (sck_lvl != (sck_last_q ^ clock_polarity_bit_i)) && !sck_lvl;
  assign trail_edge = mck_en && (sck_lvl != (sck_last_q ^ clock_polarity_bit_i)) && sck_lvl;

  // ************************************************************
  // Shift engine
  // ************************************************************
  sspis_state_type state_q;
  logic [7:0]      shift_q;
  logic [3:0]      bits_q;
  logic            out_edge;
  logic            in_edge;
  logic            last_bit;

  // Phase 1 moves output to the trailing edge of the previous half period.
  assign out_edge = data_phase_bit_i ? trail_edge : lead_edge;
  assign in_edge  = data_phase_bit_i ? lead_edge : trail_edge;
  assign load     = (state_q == SSPIS_IDLE) && enable_i && !sel_sync_q[1];
  assign last_bit = in_edge && (bits_q == `SSPIS_BITS_PER_XFER - 4'h1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= SSPIS_IDLE;
      shift_q <= 8'h00;
      bits_q  <= 4'h0;
      sdo_o   <= 1'b0;
    end else begin
      case (state_q)
        SSPIS_IDLE: begin
          if (load) begin
            shift_q <= data_q[7:0];
            bits_q  <= 4'h0;
            sdo_o   <= data_phase_bit_i ? (msb_first_i ? data_q[7] : data_q[0]) : sdo_o;
            state_q <= SSPIS_SHIFT;
          end
        end
        SSPIS_SHIFT: begin
          if (sel_sync_q[1] || !enable_i) begin
            state_q <= SSPIS_IDLE;
          end else begin
            if (out_edge && !(data_phase_bit_i && bits_q == 4'h0)) begin
              sdo_o <= msb_first_i ? shift_q[7] : shift_q[0];
            end
            if (in_edge) begin
              shift_q <= msb_first_i ? {shift_q[6:0], sdi_sync_q[1]}
                                     : {sdi_sync_q[1], shift_q[7:1]};
              bits_q  <= bits_q + 4'h1;
              if (last_bit) begin
                state_q <= SSPIS_DONE;
              end
            end
          end
        end
        SSPIS_DONE: begin
          state_q <= SSPIS_IDLE;
        end
        default: begin
          state_q <= SSPIS_IDLE;
        end
      endcase
    end
  end

  assign busy_o   = (state_q != SSPIS_IDLE);
  assign sdo_oe_o = busy_o;

  // ************************************************************
  // Receive buffer: two entries, so a stalled reader loses no word until a third arrives
  // ************************************************************
  logic [7:0] rxb_q [2];
  logic [1:0] rx_cnt_q;
  logic       rx_pop;
  logic       rx_rd;

  assign rx_push    = (state_q == SSPIS_DONE);
  assign rx_rd      = rx_ready_i || rd_strobe_i;
  assign rx_pop     = rx_rd && (rx_cnt_q != 2'h0);
  assign rx_valid_o = (rx_cnt_q != 2'h0);
  assign rx_data_o  = rxb_q[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxb_q[0] <= 8'h00;
      rxb_q[1] <= 8'h00;
      rx_cnt_q <= 2'h0;
    end else begin
      if (rx_pop) begin
        rxb_q[0] <= (rx_push && rx_cnt_q == 2'h1) ? shift_q : rxb_q[1];
      end else if (rx_push && rx_cnt_q == 2'h0) begin
        rxb_q[0] <= shift_q;
      end
      if (rx_push && (rx_cnt_q - 2'(rx_pop)) == 2'h1) begin
        rxb_q[1] <= shift_q;
      end
      if (rx_push && !(rx_cnt_q == 2'h2 && !rx_pop)) begin
        rx_cnt_q <= rx_cnt_q + 2'h1 - 2'(rx_pop);
      end else begin
        rx_cnt_q <= rx_cnt_q - 2'(rx_pop);
      end
    end
  end

  // ************************************************************
  // Status and interrupt
  // ************************************************************
  // A byte landing in the same cycle as the clearing read keeps the flag set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bff_q     <= 1'b0;
      overrun_o <= 1'b0;
    end else begin
      bff_q     <= rx_push || (bff_q && !rd_strobe_i);
      overrun_o <= overrun_o || (rx_push && rx_cnt_q == 2'h2 && !rx_pop);
    end
  end

  assign bfree_pulse = load;

  // Select is read live each cycle so a change before the last bit takes effect.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      intr_o <= 1'b0;
    end else begin
      intr_o <= interrupt_source_select_i ? bfree_pulse : rx_push;
    end
  end

  assign buffer_full_flag_o = bff_q;

endmodule
`default_nettype wire

// ===== sspis_slave_tb.sv
/* Self-checking bench for the serial slave channel.
   Assumes the package, design, checker and master model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module sspis_slave_tb;
  import sspis_pkg::*;
  logic clk_i, rst_i, en, psel, isel, wv, rs, rr, go, rdy, bff, busy, ovr, intr, mst;
  logic rxv, sck, seln, sdi, sdo, oe, done;
  logic dap, ckp, msb;
  logic [3:0] plo, phi;
  logic [7:0] tx, rdd, rxd, got;
  sspis_word_type wd;
  int bad_count = 0, check_count = 0, ic = 0;
  sspis_slave sspis_slave_inst (.clk_i(clk_i), .rst_i(rst_i), .enable_i(en),
    .prescaler_select_bit_i(psel), .prescale_field_low_i(plo), .prescale_field_high_i(phi),
    .interrupt_source_select_i(isel), .data_phase_bit_i(dap), .clock_polarity_bit_i(ckp),
    .msb_first_i(msb), .wr_valid_i(wv), .wr_ready_o(rdy), .wr_data_i(wd), .rd_strobe_i(rs),
    .rd_data_o(rdd), .rx_data_o(rxd), .rx_valid_o(rxv), .rx_ready_i(rr),
    .buffer_full_flag_o(bff), .busy_o(busy), .overrun_o(ovr), .intr_o(intr),
    .master_sck_toggle_o(mst), .sck_i(sck), .sel_n_i(seln), .sdi_i(sdi), .sdo_o(sdo),
    .sdo_oe_o(oe));
  sspis_master_model sspis_master_model_inst (.clk_i(clk_i), .go_i(go), .tx_i(tx),
    .pha_i(dap), .pol_i(ckp), .msb_i(msb), .sdo_i(sdo), .sdo_oe_i(oe), .sck_o(sck),
    .sel_n_o(seln), .sdi_o(sdi), .got_o(got), .done_o(done));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(negedge clk_i) if (intr === 1'b1) ic++;
  task automatic stop_test();
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    check_count++;
    if (e !== s) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(int n); repeat (n) @(negedge clk_i); endtask
  // Each strobe is followed by an idle cycle so back-to-back calls never
  // lower and raise it in one time step.
  task automatic wr(logic [15:0] d);
    wv = 1'b1;
    wd = d;
    cyc(1);
    wv = 1'b0;
    cyc(1);
  endtask
  task automatic rd();
    rs = 1'b1;
    cyc(1);
    rs = 1'b0;
    cyc(1);
  endtask
  task automatic pop();
    rr = 1'b1;
    cyc(1);
    rr = 1'b0;
    cyc(1);
  endtask
  task automatic xfer(logic [7:0] t);
    tx = t;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    for (int n = 0; n < 400 && done !== 1'b1; n++) cyc(1);
    cyc(8);
  endtask
  // Toggle count over 96 clocks, allowing one for the window's phase.
  task automatic t_rate(logic s, logic [3:0] lo, logic [3:0] hi, logic [6:0] dv);
    int n, e;
    logic p;
    n = 0;
    e = 96 / ((dv + 1) * (1 << (s ? hi : lo)));
    psel = s; plo = lo; phi = hi;
    wr({dv, 9'h000});
    cyc(20);
    repeat (96) begin p = mst; cyc(1); if (mst !== p) n++; end
    chk("toggles", e[15:0], (n >= e - 1 && n <= e + 1) ? e[15:0] : n[15:0]);
  endtask
  task automatic t_single();
    int b;
    chk("wr_ready", 16'h1, rdy);
    wr(16'h02A5);
    b = ic;
    xfer(8'h3C);
    chk("sdo byte", 16'hA5, got);
    chk("rx byte", 16'h3C, rxd);
    chk("bff set", 16'h1, bff);
    b = ic - b;
    chk("end intr", 16'h1, b[15:0]);
    chk("rd data", 16'hA5, rdd);
    wr(16'h0211);
    wr(16'h0296);
    xfer(8'hC3);
    chk("overwrite", 16'h96, got);
    xfer(8'h77);
    chk("overrun", 16'h1, ovr);
    chk("rx head", 16'h3C, rxd);
    pop();
    chk("rx next", 16'hC3, rxd);
    pop();
    chk("rx empty", 16'h0, rxv);
    rd();
    chk("bff clear", 16'h0, bff);
  endtask
  task automatic t_cont();
    int b;
    isel = 1'b1;
    wr(16'h02E7);
    b = ic;
    fork
      xfer(8'h5B);
      begin
        cyc(30);
        chk("cont busy", 16'h1, busy);
        chk("cont oe", 16'h1, oe);
        rd();
        chk("cont rd live", 16'hE7, rdd);
        isel = 1'b0;
      end
    join
    chk("cont sdo", 16'hE7, got);
    chk("cont rd", 16'hE7, rdd);
    b = ic - b;
    chk("intr count", 16'h2, b[15:0]);
    chk("cont rx", 16'h5B, rxd);
    rd();
  endtask
  task automatic t_abort();
    int b;
    b = ic;
    wr(16'h02AA);
    fork
      xfer(8'h0F);
      begin
        cyc(40);
        en = 1'b0;
        cyc(2);
        chk("abort busy", 16'h0, busy);
        chk("abort oe", 16'h0, oe);
      end
    join
    chk("abort bff", 16'h0, bff);
    b = ic - b;
    chk("abort intr", 16'h0, b[15:0]);
    en = 1'b1;
    wr(16'h0281);
    xfer(8'h18);
    chk("restart rx", 16'h18, rxd);
    chk("restart sdo", 16'h81, got);
  endtask
  // One byte each way under a given phase, polarity and bit order.
  task automatic t_mode(logic a, logic p, logic m, logic [7:0] d, logic [7:0] t);
    rd();
    dap = a;
    ckp = p;
    msb = m;
    cyc(4);
    wr({8'h02, d});
    xfer(t);
    chk("mode sdo", {8'h00, d}, got);
    chk("mode rx", {8'h00, t}, rxd);
  endtask
  initial begin
    #2000000;
    bad_count++;
    stop_test();
  end
  initial begin
    rst_i = 1'b1; en = 1'b1; psel = 1'b0; plo = 4'h0; phi = 4'h0; isel = 1'b0;
    wv = 1'b0; wd = 16'h0000; rs = 1'b0; rr = 1'b0; go = 1'b0; tx = 8'h00;
    dap = 1'b0; ckp = 1'b0; msb = 1'b1;
    cyc(6);
    rst_i = 1'b0;
    cyc(1);
    t_rate(1'b0, 4'h0, 4'h9, 7'h01);
    t_rate(1'b0, 4'h1, 4'h9, 7'h01);
    t_rate(1'b1, 4'h0, 4'h2, 7'h01);
    t_rate(1'b0, 4'h0, 4'h0, 7'h03);
    t_single();
    t_cont();
    t_abort();
    t_mode(1'b1, 1'b0, 1'b1, 8'h5A, 8'hC6);
    t_mode(1'b0, 1'b1, 1'b0, 8'h93, 8'h2D);
    t_mode(1'b1, 1'b1, 1'b0, 8'h4E, 8'hB1);
    stop_test();
  end
endmodule
`default_nettype wire
